// ===== core/supervisor_consts.vh
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS      10
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define RESET_HOLD_MS      500
`define WDOG_TIMEOUT_MS    700
`define STROBE_MIN_NS      500
`define STROBE_MIN_CYCLES  ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_TICKS     10

`endif

// ===== core/level_sync.v
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Three-stage synchroniser with agreement
// ****************************************
module level_sync (
    // Clock and reset
    input  wire clk_in,
    input  wire rstn_in,
    // Level
    input  wire async_in,
    output reg  level_out
);
    reg [2:0] sync_q;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            sync_q    <= 3'h0;
            level_out <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], async_in};
            // Change counts only once stages two and three agree
            if (sync_q[1] == sync_q[2]) begin
                level_out <= sync_q[2];
            end
        end
    end
endmodule // level_sync

`default_nettype wire

// ===== core/supervisor_watchdog_reset.v
`include "supervisor_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module supervisor_watchdog_reset #(
    parameter TICK_CYCLES    = `TICK_CYCLES,
    parameter RESET_HOLD_MS  = `RESET_HOLD_MS,
    parameter WDOG_TIMEOUT_MS = `WDOG_TIMEOUT_MS,
    parameter STROBE_CYCLES  = `STROBE_MIN_CYCLES,
    parameter DEBOUNCE_TICKS = `DEBOUNCE_TICKS
) (
    // Clock and reset
    input  wire clk_in,
    input  wire rstn_in,
    // Analog comparator levels
    input  wire supply_good_in,
    input  wire strobe_low_level_in,
    input  wire hard_low_in,
    // Shared reset/strobe pin, open drain
    output wire reset_strobe_pin_out,
    output wire reset_strobe_pin_oe_out,
    // Status
    output reg  reset_active_out
);
    // ****************************************
    // States
    // ****************************************
    // One-hot; an illegal code falls back to hold
    localparam [2:0] ST_HOLD  = 3'h1;
    localparam [2:0] ST_WATCH = 3'h2;
    localparam [2:0] ST_PULSE = 3'h4;

    // ****************************************
    // Helpers
    // ****************************************
    // True on the last count of an interval of the given length
    function is_last;
        input [15:0] cnt_val;
        input [31:0] len_val;
        begin
            is_last = ({16'h0000, cnt_val} == (len_val - 32'h00000001));
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Comparator levels come from the analog side, off this clock
    wire supply_good_s;
    wire strobe_s;
    wire hard_low_s;

    level_sync u_sync_supply (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .async_in  (supply_good_in),
        .level_out (supply_good_s)
    );
    level_sync u_sync_strobe (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .async_in  (strobe_low_level_in),
        .level_out (strobe_s)
    );
    level_sync u_sync_hard (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .async_in  (hard_low_in),
        .level_out (hard_low_s)
    );

    // ****************************************
    // Millisecond timebase
    // ****************************************
    // One pulse per millisecond; hold, watchdog and debounce count these, so the first
    // interval after a restart may be up to one tick short
    reg  [31:0] tick_cnt_q;
    reg         tick_q;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q     <= 1'b0;
        end
    end

    // ****************************************
    // Strobe qualification
    // ****************************************
    // Strobe only when dipped to strobe level but not to hard low
    reg  [15:0] strb_cnt_q;
    reg         strobe_seen_q;
    wire        strobe_level = strobe_s && !hard_low_s;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            strb_cnt_q    <= 16'h0;
            strobe_seen_q <= 1'b0;
        end else begin
            strobe_seen_q <= 1'b0;
            if (!strobe_level) begin
                strb_cnt_q <= 16'h0;
            end else if (strb_cnt_q < STROBE_CYCLES) begin
                strb_cnt_q <= strb_cnt_q + 16'h1;
                // Fires once per dip, on reaching the minimum width
                if (is_last(strb_cnt_q, STROBE_CYCLES)) begin
                    strobe_seen_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Override debounce
    // ****************************************
    // Our own pull-down also reads as hard low; only count outside it
    // The synchroniser delays the line by four edges, so the mask trails
    // our release by as long; a fast timebase would otherwise take that
    // tail for a press and lock the part in reset
    reg  [3:0]  own_pull_q;
    wire        own_pull = reset_active_out || (|own_pull_q);
    reg  [15:0] deb_cnt_q;
    reg         override_q;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            own_pull_q <= 4'hF;
        end else begin
            own_pull_q <= {own_pull_q[2:0], reset_active_out};
        end
    end

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            deb_cnt_q  <= 16'h0;
            override_q <= 1'b0;
        end else begin
            override_q <= 1'b0;
            if (!hard_low_s || own_pull) begin
                deb_cnt_q <= 16'h0;
            end else if (tick_q) begin
                if (is_last(deb_cnt_q, DEBOUNCE_TICKS)) begin
                    deb_cnt_q  <= 16'h0;
                    override_q <= 1'b1;
                end else begin
                    deb_cnt_q <= deb_cnt_q + 16'h1;
                end
            end
        end
    end

    // ****************************************
    // Reset sequencer
    // ****************************************
    reg  [2:0]  state_q;
    reg  [15:0] ms_cnt_q;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q          <= ST_HOLD;
            ms_cnt_q         <= 16'h0;
            reset_active_out <= 1'b1;
        end else if (!supply_good_s) begin
            // Supply loss wins over every state at once
            state_q          <= ST_HOLD;
            ms_cnt_q         <= 16'h0;
            reset_active_out <= 1'b1;
        end else begin
            case (state_q)
                ST_HOLD, ST_PULSE: begin
                    // Strobes are ignored here; the watchdog restarts at release
                    reset_active_out <= 1'b1;
                    if (tick_q) begin
                        if (is_last(ms_cnt_q, RESET_HOLD_MS)) begin
                            // Watchdog restarts from release
                            state_q          <= ST_WATCH;
                            ms_cnt_q         <= 16'h0;
                            reset_active_out <= 1'b0;
                        end else begin
                            ms_cnt_q <= ms_cnt_q + 16'h1;
                        end
                    end
                end
                ST_WATCH: begin
                    reset_active_out <= 1'b0;
                    // Override outranks a strobe so a held button always resets
                    if (override_q) begin
                        state_q          <= ST_PULSE;
                        ms_cnt_q         <= 16'h0;
                        reset_active_out <= 1'b1;
                    end else if (strobe_seen_q) begin
                        ms_cnt_q <= 16'h0;
                    end else if (tick_q) begin
                        if (is_last(ms_cnt_q, WDOG_TIMEOUT_MS)) begin
                            state_q          <= ST_PULSE;
                            ms_cnt_q         <= 16'h0;
                            reset_active_out <= 1'b1;
                        end else begin
                            ms_cnt_q <= ms_cnt_q + 16'h1;
                        end
                    end
                end
                default: begin
                    state_q          <= ST_HOLD;
                    ms_cnt_q         <= 16'h0;
                    reset_active_out <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Pin level is always low; enable alone pulls the line
    assign reset_strobe_pin_out    = 1'b0;
    assign reset_strobe_pin_oe_out = reset_active_out;
endmodule // supervisor_watchdog_reset

`default_nettype wire

// ===== tb/supervisor_watchdog_reset_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module supervisor_watchdog_reset_chk #(
    parameter int TICK_CYCLES = 10, RESET_HOLD_MS = 5, WDOG_TIMEOUT_MS = 7, DEBOUNCE_TICKS = 2
) (
    input wire logic clk_in, rstn_in, supply_good_in, strobe_low_level_in, hard_low_in,
    input wire logic reset_strobe_pin_out, reset_strobe_pin_oe_out, reset_active_out
);
    // ****
    // Cycle counters: the timebase tick allows one tick of slack either way
    // ****
    localparam int HMIN = (RESET_HOLD_MS - 1) * TICK_CYCLES;
    localparam int WMIN = (WDOG_TIMEOUT_MS - 1) * TICK_CYCLES;
    localparam int WMAX = (WDOG_TIMEOUT_MS + 1) * TICK_CYCLES + 8;
    localparam int DB = (DEBOUNCE_TICKS + 1) * TICK_CYCLES + 8;
    logic [15:0] hi_q, lo_q, hl_q;
    always_ff @(posedge clk_in) begin
        hi_q <= (!rstn_in || !reset_active_out) ? 16'h0000 : hi_q + 16'h0001;
        lo_q <= (!rstn_in || reset_active_out || (strobe_low_level_in && !hard_low_in))
            ? 16'h0000 : lo_q + 16'h0001;
        hl_q <= (!rstn_in || !hard_low_in) ? 16'h0000 : hl_q + 16'h0001;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_PIN_LOW: assert property (!reset_strobe_pin_out)
        else $error("pin data not low");
    AST_OE_MATCH: assert property (reset_strobe_pin_oe_out == reset_active_out)
        else $error("pin enable differs from reset state");
    AST_SUPPLY_LOW: assert property (!supply_good_in [*6] |-> reset_active_out)
        else $error("no reset on low supply");
    AST_HOLD_MIN: assert property ($fell(reset_active_out) |-> hi_q >= HMIN)
        else $error("reset pulse too short");
    AST_WDOG_MAX: assert property (lo_q <= WMAX)
        else $error("watchdog did not fire");
    AST_WDOG_MIN: assert property ($rose(reset_active_out) && supply_good_in
        && !$past(hard_low_in) |-> lo_q >= WMIN) else $error("watchdog fired early");
    AST_OVERRIDE: assert property (hl_q == DB |-> reset_active_out)
        else $error("override not taken");
    AST_RESET_HELD: assert property (disable iff (1'b0) !rstn_in |=> reset_active_out)
        else $error("no reset while held");
endmodule // supervisor_watchdog_reset_chk
bind supervisor_watchdog_reset supervisor_watchdog_reset_chk #(.TICK_CYCLES(TICK_CYCLES),
    .RESET_HOLD_MS(RESET_HOLD_MS), .WDOG_TIMEOUT_MS(WDOG_TIMEOUT_MS),
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS)) chk (.*);
`default_nettype wire

// ===== tb/proc_strobe_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Processor pulling the lower divider resistor low at a steady rate
// ****
module proc_strobe_model (
    input wire logic       clk_in,
    input wire logic       en_in,
    input wire logic [7:0] gap_in,
    output var logic       strobe_out
);
    logic [7:0] cnt_q = 8'h00;
    always_ff @(posedge clk_in) begin
        cnt_q <= (!en_in || cnt_q >= gap_in) ? 8'h00 : cnt_q + 8'h01;
        strobe_out <= en_in && cnt_q < 8'h05;
    end
endmodule // proc_strobe_model
`default_nettype wire

// ===== tb/test_supervisor_watchdog_reset.sv
`timescale 1ns/100ps
`default_nettype none
module test_supervisor_watchdog_reset;
    // ****
    // Wire-OR of the shared line: device pull and button give hard low
    // ****
    logic clk_in = 1'b0, rstn_in = 1'b0, sup = 1'b0, en = 1'b0, btn = 1'b0;
    logic [7:0] gap = 8'h28;
    wire logic strobe, pin_oe, pin_d, active;
    wire logic hard_low = pin_oe | btn;
    wire logic strobe_low = hard_low | strobe;
    int num_errors = 0, n_checks = 0, cyc_q = 0;
    // Row: supply, strobing, button, expected reset, cycles
    logic [15:0] rows [14] = '{16'hD014, 16'hC028, 16'hC0C8, 16'h500A, 16'h9014, 16'h8028,
        16'h8028, 16'h9028, 16'h803C, 16'h9046, 16'hC064, 16'hF014, 16'hD014, 16'hC028};
    always #5 clk_in = ~clk_in;
    supervisor_watchdog_reset #(.TICK_CYCLES(2), .RESET_HOLD_MS(20), .WDOG_TIMEOUT_MS(40),
        .STROBE_CYCLES(3), .DEBOUNCE_TICKS(3)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .supply_good_in(sup), .strobe_low_level_in(strobe_low), .hard_low_in(hard_low),
        .reset_strobe_pin_out(pin_d), .reset_strobe_pin_oe_out(pin_oe),
        .reset_active_out(active));
    proc_strobe_model proc (.clk_in(clk_in), .en_in(en), .gap_in(gap), .strobe_out(strobe));
    task automatic check(input logic exp);
        n_checks++;
        if (active !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, active, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc_q++;
        if (cyc_q == 2000) begin
            num_errors++;
            stop_test;
        end
    end
    initial begin
        repeat (12) @(negedge clk_in);
        check(1'b1);
        rstn_in = 1'b1;
        foreach (rows[i]) begin
            {sup, en, btn} = rows[i][15:13];
            repeat (rows[i][11:0]) @(negedge clk_in);
            check(rows[i][12]);
        end
        rstn_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check(1'b1);
        repeat (9) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (30) @(negedge clk_in);
        check(1'b1);
        repeat (30) @(negedge clk_in);
        check(1'b0);
        // Strobes just inside the timeout must never let the watchdog fire
        gap = 8'h46;
        repeat (6) begin
            repeat (50) @(negedge clk_in);
            check(1'b0);
        end
        stop_test;
    end
endmodule // test_supervisor_watchdog_reset
`default_nettype wire
